// ### inc/fis_pkg.sv
// Purpose: shared constants for the flash serial slave and its bus master
// Assumes: master clock 20 MHz, slave oscillator period 30 ns
// Notes: all counts derived from printed times
package fis_pkg;
   // master clock and bus timing, least times round up
   localparam int CLK_NS       = 50;
   localparam int LOW_NS       = 4700;
   localparam int HIGH_NS      = 4000;
   localparam int BUF_NS       = 4700;
   localparam int SU_STA_NS    = 4700;
   localparam int HD_STA_NS    = 4000;
   localparam int SU_STO_NS    = 4000;
   localparam int LOW_CYC      = (LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int HIGH_CYC     = (HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUF_CYC      = (BUF_NS + CLK_NS - 1) / CLK_NS;
   localparam int SU_STA_CYC   = (SU_STA_NS + CLK_NS - 1) / CLK_NS;
   localparam int HD_STA_CYC   = (HD_STA_NS + CLK_NS - 1) / CLK_NS;
   localparam int SU_STO_CYC   = (SU_STO_NS + CLK_NS - 1) / CLK_NS;
   localparam int MT_W         = 7;

   // slave oscillator and flash cycle times, longest times round down
   localparam int LINK_NS        = 30;
   localparam int WRITE_US       = 110;
   localparam int SECTOR_ERASE_MS = 501;
   localparam int FULL_ERASE_MS  = 1002;
   localparam int WRITE_CYC      = WRITE_US * 1000 / LINK_NS;
   localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * 1000000 / LINK_NS;
   localparam int FULL_ERASE_CYC = FULL_ERASE_MS * 1000000 / LINK_NS;
   localparam int ST_W           = 26;

   // slave address and memory
   localparam logic [3:0] ADDR_HI_DEF  = 4'ha;
   localparam logic [2:0] ADDR_LO_DEF  = 3'h0;
   localparam logic [2:0] ERASE_LO     = 3'h7;
   localparam int         MEM_BYTES_DEF = 256;
   localparam logic [7:0] ERASED_BYTE  = 8'hff;

   typedef enum logic {FIS_ERASE_NONE, FIS_ERASE_FULL} fis_erase_t;

   // master register map
   localparam logic [31:0] OFF_CMD    = 32'h0000_0000;
   localparam logic [31:0] OFF_STATUS = 32'h0000_0004;
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_NACK_BIT = 2;
   localparam int CMD_TX_LSB   = 8;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_NACK_BIT  = 1;
   localparam int ST_RX_LSB    = 8;
   localparam logic [1:0] CMD_START = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ  = 2'h2;
   localparam logic [1:0] CMD_STOP  = 2'h3;
endpackage : fis_pkg

// ### inc/fis_link_if.sv
// Purpose: open-drain two-wire link between master and flash slave
// Assumes: pull-ups on both wires
// Notes: wire levels resolved here from the enables
`timescale 1ns/1ps
interface fis_link_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;

   assign scl = scl_m_oe ? scl_m_o : 1'b1;
   assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

   modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe,
                   input scl, input sda);
   modport slave  (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : fis_link_if

// ### core/fis_master.sv
// Purpose: byte-level two-wire bus master commanded over APB
// Assumes: slave never stretches the clock
// Notes: one command at a time; commands written while busy are dropped
`timescale 1ns/1ps
module fis_master (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   fis_link_if.master       link
);
   typedef enum {M_IDLE, M_START, M_BIT, M_STOP} fis_mst_t;

   fis_mst_t              state;
   logic [1:0]            ph;
   logic [fis_pkg::MT_W-1:0] tmr;
   logic [3:0]            bitn;
   logic [7:0]            sh;
   logic [7:0]            rx_data;
   logic                  is_read;
   logic                  ack_out;
   logic                  busy;
   logic                  nack_seen;
   logic                  scl_low;
   logic                  sda_low;
   logic [1:0]            sda_q;
   logic                  sda_s;
   logic                  wr_cmd;
   logic [1:0]            code;

   assign link.scl_m_o  = 1'b0;
   assign link.scl_m_oe = scl_low;
   assign link.sda_m_o  = 1'b0;
   assign link.sda_m_oe = sda_low;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_q <= 2'h3;
      end else begin
         sda_q <= {sda_q[0], link.sda};
      end
   end
   assign sda_s = sda_q[1];

   // register slave: zero wait, read data captured in the setup cycle
   assign pready = 1'b1;
   assign wr_cmd = psel & penable & pwrite & (paddr == fis_pkg::OFF_CMD);
   assign code   = pwdata[fis_pkg::CMD_CODE_LSB +: 2];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel & !penable) begin
         prdata  <= 32'h0000_0000;
         pslverr <= !(paddr == fis_pkg::OFF_CMD || paddr == fis_pkg::OFF_STATUS);
         if (paddr == fis_pkg::OFF_STATUS) begin
            prdata[fis_pkg::ST_BUSY_BIT]     <= busy;
            prdata[fis_pkg::ST_NACK_BIT]     <= nack_seen;
            prdata[fis_pkg::ST_RX_LSB +: 8]  <= rx_data;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= M_IDLE;
         ph        <= 2'h0;
         tmr       <= '0;
         bitn      <= 4'h0;
         sh        <= 8'hff;
         rx_data   <= 8'h00;
         is_read   <= 1'b0;
         ack_out   <= 1'b0;
         busy      <= 1'b0;
         nack_seen <= 1'b0;
         scl_low   <= 1'b0;
         sda_low   <= 1'b0;
      end else if (state == M_IDLE) begin
         if (wr_cmd) begin
            busy    <= 1'b1;
            ph      <= 2'h0;
            tmr     <= '0;
            bitn    <= 4'h0;
            ack_out <= pwdata[fis_pkg::CMD_NACK_BIT];
            is_read <= (code == fis_pkg::CMD_READ);
            sh      <= (code == fis_pkg::CMD_READ) ? 8'hff : pwdata[fis_pkg::CMD_TX_LSB +: 8];
            unique case (code)
               fis_pkg::CMD_START: state <= M_START;
               fis_pkg::CMD_STOP:  state <= M_STOP;
               default:            state <= M_BIT;
            endcase
         end
      end else if (tmr != '0) begin
         tmr <= tmr - 1'b1;
      end else begin
         unique case (state)
            M_START: begin
               ph <= ph + 2'h1;
               unique case (ph)
                  2'h0: begin
                     sda_low <= 1'b0;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::LOW_CYC);
                  end
                  2'h1: begin
                     scl_low <= 1'b0;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::SU_STA_CYC);
                  end
                  2'h2: begin
                     sda_low <= 1'b1;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::HD_STA_CYC);
                  end
                  2'h3: begin
                     scl_low <= 1'b1;
                     busy    <= 1'b0;
                     state   <= M_IDLE;
                  end
               endcase
            end
            M_BIT: begin
               unique case (ph)
                  2'h0: begin
                     sda_low <= (bitn == 4'h8) ? (is_read & !ack_out) : !sh[7];
                     tmr     <= fis_pkg::MT_W'(fis_pkg::LOW_CYC);
                     ph      <= 2'h1;
                  end
                  2'h1: begin
                     scl_low <= 1'b0;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::HIGH_CYC);
                     ph      <= 2'h2;
                  end
                  default: begin
                     scl_low <= 1'b1;
                     ph      <= 2'h0;
                     if (bitn == 4'h8) begin
                        if (!is_read) begin
                           nack_seen <= sda_s;
                        end else begin
                           rx_data <= sh;
                        end
                        busy  <= 1'b0;
                        state <= M_IDLE;
                     end else begin
                        sh   <= {sh[6:0], sda_s};
                        bitn <= bitn + 4'h1;
                     end
                  end
               endcase
            end
            M_STOP: begin
               ph <= ph + 2'h1;
               unique case (ph)
                  2'h0: begin
                     sda_low <= 1'b1;
                     scl_low <= 1'b1;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::LOW_CYC);
                  end
                  2'h1: begin
                     scl_low <= 1'b0;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::SU_STO_CYC);
                  end
                  2'h2: begin
                     sda_low <= 1'b0;
                     tmr     <= fis_pkg::MT_W'(fis_pkg::BUF_CYC);
                  end
                  2'h3: begin
                     busy  <= 1'b0;
                     state <= M_IDLE;
                  end
               endcase
            end
            default: state <= M_IDLE;
         endcase
      end
   end
endmodule : fis_master

// ### core/fis_slave.sv
// Purpose: two-wire serial slave over a byte-wide flash array
// Assumes: clocked by the always-running internal oscillator
// Notes: one byte written per transaction; flash write only clears bits
// Contract
// - sequential read from current or random address
// - acked byte followed by next address byte
// - master ends read with nack then stop
// - master keeps bus free between stop/start
// - master keeps clock low/high minimum times
// - write cycle ends within its longest time
// - erase cycles end within longest times
// - upper four address bits are a parameter
// - read-only build refuses writes and erases
// - memory size parameter sets address width
// - oscillator enable held on always
// - write protect and erase method built-time
// - address advances after each byte read
// - address ending 111 triggers full erase
// - erase starts only after stop
// - write protect refuses full-erase address
`timescale 1ns/1ps
module fis_slave #(
   parameter logic [3:0]          ADDR_HI     = fis_pkg::ADDR_HI_DEF,
   parameter logic [2:0]          ADDR_LO     = fis_pkg::ADDR_LO_DEF,
   parameter int                  MEM_BYTES   = fis_pkg::MEM_BYTES_DEF,
   parameter bit                  READ_ONLY   = 1'b0,
   parameter bit                  HAS_WP      = 1'b1,
   parameter fis_pkg::fis_erase_t ERASE_MODE  = fis_pkg::FIS_ERASE_FULL,
   parameter int                  ERASE_CYC   = fis_pkg::FULL_ERASE_CYC
) (
   input  wire logic  link_clk,
   input  wire logic  rst,
   input  wire logic  wp,
   output logic       busy,
   output logic       osc_ena,
   fis_link_if.slave  link
);
   localparam int AW = $clog2(MEM_BYTES);
   typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} fis_slv_t;
   typedef enum {K_DEV, K_BADDR, K_DATA, K_NONE} fis_kind_t;

   fis_slv_t            state;
   fis_kind_t           kind;
   logic [2:0]          scl_q;
   logic [2:0]          sda_q;
   logic                rise;
   logic                fall;
   logic                start_c;
   logic                stop_c;
   logic [7:0]          rx;
   logic [7:0]          sh;
   logic [3:0]          cnt;
   logic [AW-1:0]       addr;
   logic                to_tx;
   logic                sda_low;
   logic                wr_pend;
   logic [7:0]          wr_data;
   logic [AW-1:0]       wr_addr;
   logic                erase_req;
   logic [fis_pkg::ST_W-1:0] tmr;
   logic [7:0]          mem [MEM_BYTES];
   logic                dev_hit;
   logic                erase_hit;
   logic                erase_ok;
   logic [1:0]          wp_q;

   assign osc_ena       = 1'b1;
   assign link.sda_s_o  = 1'b0;
   assign link.sda_s_oe = sda_low;
   assign busy          = (tmr != '0);

   // two-stage sync, third stage for edges
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], link.scl};
         sda_q <= {sda_q[1:0], link.sda};
      end
   end
   assign rise    = scl_q[1] & !scl_q[2];
   assign fall    = !scl_q[1] & scl_q[2];
   // start and stop from synced samples
   assign start_c = scl_q[1] & scl_q[2] & sda_q[2] & !sda_q[1];
   assign stop_c  = scl_q[1] & scl_q[2] & !sda_q[2] & sda_q[1];

   assign dev_hit   = (rx[7:1] == {ADDR_HI, ADDR_LO});
   assign erase_hit = (ERASE_MODE == fis_pkg::FIS_ERASE_FULL) && !READ_ONLY &&
                      (rx[7:1] == {ADDR_HI, fis_pkg::ERASE_LO});
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         wp_q <= 2'h3;
      end else begin
         wp_q <= {wp_q[0], wp};
      end
   end
   assign erase_ok  = erase_hit && !(HAS_WP && wp_q[1]);

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         state     <= D_IDLE;
         kind      <= K_DEV;
         rx        <= 8'h00;
         sh        <= 8'hff;
         cnt       <= 4'h0;
         addr      <= '0;
         to_tx     <= 1'b0;
         sda_low   <= 1'b0;
         wr_pend   <= 1'b0;
         wr_data   <= 8'hff;
         wr_addr   <= '0;
         erase_req <= 1'b0;
      end else if (stop_c) begin
         state     <= D_IDLE;
         sda_low   <= 1'b0;
         wr_pend   <= 1'b0;
         erase_req <= 1'b0;
      end else if (start_c) begin
         state   <= D_RX;
         kind    <= K_DEV;
         cnt     <= 4'h0;
         sda_low <= 1'b0;
      end else begin
         unique case (state)
            D_IDLE: sda_low <= 1'b0;
            D_RX: begin
               if (rise && cnt != 4'h8) begin
                  rx  <= {rx[6:0], sda_q[1]};
                  cnt <= cnt + 4'h1;
               end else if (fall && cnt == 4'h8) begin
                  state   <= D_ACK;
                  sda_low <= 1'b1;
                  unique case (kind)
                     K_DEV: begin
                        if (busy || !(dev_hit || erase_ok)) begin
                           state   <= D_IDLE;
                           sda_low <= 1'b0;
                        end
                        to_tx     <= rx[0] & !erase_hit;
                        kind      <= erase_hit ? K_NONE : K_BADDR;
                        erase_req <= erase_ok & !busy;
                     end
                     K_BADDR: begin
                        addr <= rx[AW-1:0];
                        kind <= K_DATA;
                     end
                     K_DATA: begin
                        if (READ_ONLY) begin
                           state   <= D_IDLE;
                           sda_low <= 1'b0;
                        end
                        wr_pend <= !READ_ONLY;
                        wr_data <= rx;
                        wr_addr <= addr;
                        kind    <= K_NONE;
                     end
                     K_NONE: begin
                        state   <= D_IDLE;
                        sda_low <= 1'b0;
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (fall) begin
                  cnt <= 4'h0;
                  if (to_tx) begin
                     state   <= D_TX;
                     sh      <= mem[addr];
                     sda_low <= !mem[addr][7];
                  end else begin
                     state   <= D_RX;
                     sda_low <= 1'b0;
                  end
               end
            end
            D_TX: begin
               if (rise) begin
                  cnt <= cnt + 4'h1;
               end else if (fall) begin
                  if (cnt == 4'h8) begin
                     addr    <= addr + 1'b1;
                     sda_low <= 1'b0;
                     state   <= D_MACK;
                  end else begin
                     sda_low <= !sh[6];
                     sh      <= {sh[6:0], 1'b1};
                  end
               end
            end
            D_MACK: begin
               if (rise && sda_q[1]) begin
                  state <= D_IDLE;
               end else if (fall) begin
                  state   <= D_TX;
                  cnt     <= 4'h0;
                  sh      <= mem[addr];
                  sda_low <= !mem[addr][7];
               end
            end
            default: state <= D_IDLE;
         endcase
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= fis_pkg::ERASED_BYTE;
         end
      end else if (stop_c && erase_req) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= fis_pkg::ERASED_BYTE;
         end
      end else if (stop_c && wr_pend) begin
         mem[wr_addr] <= mem[wr_addr] & wr_data;
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         tmr <= '0;
      end else if (stop_c && erase_req) begin
         tmr <= fis_pkg::ST_W'(ERASE_CYC);
      end else if (stop_c && wr_pend) begin
         tmr <= fis_pkg::ST_W'(fis_pkg::WRITE_CYC);
      end else if (tmr != '0) begin
         tmr <= tmr - 1'b1;
      end
   end
endmodule : fis_slave

// ### verif/fis_link_assertions.sv
// Purpose: timing and handshake checks on the two-wire link
// Assumes: scl driven by the master only, 20 MHz bus clock
// Notes: counters saturate so long idle times stay legal
`timescale 1ns/1ps
module fis_link_assertions (
   input wire logic clk,
   input wire logic link_clk,
   input wire logic rst,
   input wire logic busy,
   input wire logic osc_ena,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   logic [7:0]  low_cnt;
   logic [7:0]  high_cnt;
   logic [7:0]  free_cnt;
   logic [12:0] busy_cnt;

   always_ff @(posedge clk or posedge rst) begin
      if (rst || scl) low_cnt <= 8'h0;
      else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst || !scl) high_cnt <= 8'h0;
      else if (high_cnt != 8'hff) high_cnt <= high_cnt + 8'h1;
   end
   // cycles with both wires released
   always_ff @(posedge clk or posedge rst) begin
      if (rst || !(scl && sda)) free_cnt <= 8'h0;
      else if (free_cnt != 8'hff) free_cnt <= free_cnt + 8'h1;
   end
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst || !busy) busy_cnt <= 13'h0;
      else if (busy_cnt != 13'h1fff) busy_cnt <= busy_cnt + 13'h1;
   end

   a_scl_low_min: assert property (@(posedge clk) disable iff (rst)
      $rose(scl) |-> int'(low_cnt) >= fis_pkg::LOW_CYC) else $error("scl low too short");
   a_scl_high_min: assert property (@(posedge clk) disable iff (rst)
      $fell(scl) |-> int'(high_cnt) >= fis_pkg::HIGH_CYC) else $error("scl high too short");
   a_bus_free_min: assert property (@(posedge clk) disable iff (rst)
      scl && $fell(sda) |-> int'(free_cnt) >= fis_pkg::BUF_CYC) else $error("bus free too short");
   a_slave_data_stable: assert property (@(posedge link_clk) disable iff (rst)
      scl && $past(scl) |-> $stable(sda_s_oe)) else $error("slave data moved with scl high");
   a_busy_no_ack: assert property (@(posedge link_clk) disable iff (rst)
      busy |-> !sda_s_oe) else $error("slave drives sda while busy");
   a_busy_after_stop: assert property (@(posedge link_clk) disable iff (rst)
      $rose(busy) |-> scl && sda) else $error("busy started outside a stop");
   a_busy_time_bound: assert property (@(posedge link_clk) disable iff (rst)
      int'(busy_cnt) <= fis_pkg::WRITE_CYC) else $error("internal cycle too long");
   a_osc_always_on: assert property (@(posedge link_clk) disable iff (rst)
      osc_ena) else $error("oscillator enable low");
endmodule : fis_link_assertions

// ### verif/flash_i2c_slave_read_timing_tb.sv
// Purpose: self-checking bench for master and flash slave on one link
// Assumes: erase count shortened, expected memory kept in mem
// Notes: flash writes only clear bits, so the model ands data in
`timescale 1ns/1ps
module flash_i2c_slave_read_timing_tb;
   localparam int ERASE_N = 2000;
   logic        clk      = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        wp       = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [31:0] paddr    = 32'h0;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic        osc_ena;
   logic [31:0] rd;
   logic        err;
   logic        ok;
   logic [7:0]  ptr;
   logic [7:0]  mem [256];
   int          mismatches = 0;
   int          checked    = 0;
   int          cycles     = 0;

   fis_link_if link ();
   fis_master u_fis_master (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   fis_slave #(.ERASE_CYC(ERASE_N)) u_fis_slave (.link_clk(link_clk), .rst(rst), .wp(wp),
      .busy(busy), .osc_ena(osc_ena), .link(link));
   fis_link_assertions u_fis_link_assertions (.clk(clk), .link_clk(link_clk), .rst(rst),
      .busy(busy), .osc_ena(osc_ena), .sda_s_oe(link.sda_s_oe), .scl(link.scl),
      .sda(link.sda));

   initial forever #25 clk = ~clk;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // wait ends once pready is high; only the bench timeout ends a stall
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // one link command, then wait until the engine is idle
   task automatic cmd(input logic [1:0] code, input logic [7:0] tx, input logic nk);
      apb(1'b1, fis_pkg::OFF_CMD, {16'h0, tx, 5'h0, nk, code});
      do begin
         apb(1'b0, fis_pkg::OFF_STATUS, 32'h0);
      end while (rd[fis_pkg::ST_BUSY_BIT] !== 1'b0);
   endtask : cmd

   task automatic addr_ok(input logic [7:0] a);
      cmd(fis_pkg::CMD_START, 8'h0, 1'b0);
      cmd(fis_pkg::CMD_WRITE, a, 1'b0);
      ok = (rd[fis_pkg::ST_NACK_BIT] === 1'b0);
   endtask : addr_ok

   task automatic poll(input logic [7:0] a);
      int n;
      n = 0;
      addr_ok(a);
      while (!ok && n < 40) begin
         cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
         n++;
         addr_ok(a);
      end
      chk("poll ack", 32'h1, 32'(ok));
   endtask : poll

   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      poll(8'ha0);
      cmd(fis_pkg::CMD_WRITE, a, 1'b0);
      cmd(fis_pkg::CMD_WRITE, d, 1'b0);
      chk("data ack", 32'h0, 32'(rd[fis_pkg::ST_NACK_BIT]));
      cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
      mem[a] = mem[a] & d;
      chk("busy after write", 32'h1, 32'(busy));
      addr_ok(8'ha0);
      chk("ack while busy", 32'h0, 32'(ok));
      cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
   endtask : wr_byte

   // random read from a, or current read from ptr; last byte nacked
   task automatic read_run(input logic cur, input logic [7:0] a, input int n);
      if (cur) begin
         poll(8'ha1);
      end else begin
         poll(8'ha0);
         cmd(fis_pkg::CMD_WRITE, a, 1'b0);
         addr_ok(8'ha1);
         chk("read addr ack", 32'h1, 32'(ok));
         ptr = a;
      end
      for (int i = 0; i < n; i++) begin
         cmd(fis_pkg::CMD_READ, 8'h0, i == n - 1);
         chk("read data", 32'(mem[ptr]), 32'(rd[15:8]));
         ptr = ptr + 8'h1;
      end
      cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
   endtask : read_run

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         mismatches++;
         report_and_stop();
      end
   end

   initial begin
      void'($urandom(2));
      for (int i = 0; i < 256; i++) mem[i] = 8'hff;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      chk("busy at reset", 32'h0, 32'(busy));
      chk("osc enable", 32'h1, 32'(osc_ena));
      apb(1'b0, 32'h8, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      apb(1'b0, fis_pkg::OFF_STATUS, 32'h0);
      chk("status reset", 32'h0, rd);
      wr_byte(8'hff, 8'h00);
      wr_byte(8'h00, 8'($urandom));
      wr_byte(8'h02, 8'($urandom));
      read_run(1'b0, 8'hfe, 4);
      read_run(1'b1, 8'h00, 2);
      addr_ok(8'ha2);
      chk("foreign address", 32'h0, 32'(ok));
      cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
      wp <= 1'b1;
      addr_ok(8'hae);
      chk("erase ack with wp", 32'h0, 32'(ok));
      cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
      chk("no erase with wp", 32'h0, 32'(busy));
      read_run(1'b0, 8'hff, 2);
      wp <= 1'b0;
      addr_ok(8'hae);
      chk("erase ack", 32'h1, 32'(ok));
      cmd(fis_pkg::CMD_STOP, 8'h0, 1'b0);
      chk("erase busy", 32'h1, 32'(busy));
      for (int i = 0; i < 256; i++) mem[i] = 8'hff;
      read_run(1'b0, 8'hff, 3);
      report_and_stop();
   end
endmodule : flash_i2c_slave_read_timing_tb
